// file: core/ctm_pkg.sv
// Purpose: shared constants and types of the transceiver mode controller
// Assumes: 10 MHz mclk, synchronous active-low reset
// Notes: timing figures are counts of mclk cycles derived from microseconds
package ctm_pkg;
	localparam int CTM_CLK_MHZ = 10;
	localparam int CTM_WAKE_FILTER_US = 1;
	localparam int CTM_TX_TIMEOUT_US = 300;
	localparam int CTM_BUS_TIMEOUT_US = 300;
	localparam int CTM_WAKE_FILTER_CYC = CTM_WAKE_FILTER_US * CTM_CLK_MHZ;
	localparam int CTM_TX_TIMEOUT_CYC = CTM_TX_TIMEOUT_US * CTM_CLK_MHZ;
	localparam int CTM_BUS_TIMEOUT_CYC = CTM_BUS_TIMEOUT_US * CTM_CLK_MHZ;
	localparam int CTM_CNT_W = 16;

	// transceiver modes
	typedef enum logic [1:0] {
		CTM_CAN_OFF = 2'h0,
		CTM_CAN_WAKE = 2'h1,
		CTM_CAN_NORMAL = 2'h2,
		CTM_CAN_RXONLY = 2'h3
	} ctm_can_mode_t;

	// system modes
	typedef enum logic [2:0] {
		CTM_SYS_INIT = 3'h0,
		CTM_SYS_NORMAL = 3'h1,
		CTM_SYS_STOP = 3'h2,
		CTM_SYS_SLEEP = 3'h3,
		CTM_SYS_RESTART = 3'h4,
		CTM_SYS_FAILSAFE = 3'h5,
		CTM_SYS_SWFLASH = 3'h6,
		CTM_SYS_FFLASH = 3'h7
	} ctm_sys_mode_t;

	// diagnostic code field
	localparam logic [2:0] CTM_DIAG_NONE = 3'h0;
	localparam logic [2:0] CTM_DIAG_TX_GND = 3'h1;
	localparam logic [2:0] CTM_DIAG_BUS_DOM = 3'h2;
	localparam logic [2:0] CTM_DIAG_TXRX_SHORT = 3'h3;
	localparam logic [2:0] CTM_DIAG_RX_PIN = 3'h4;
	localparam int CTM_WAKE_REG_ADDR = 0;
endpackage

// file: core/ctm_link_if.sv
// Purpose: pins between host controller and transceiver mode logic
// Assumes: one clock, both ends on mclk
// Notes: the command strobe stands in for one decoded SPI word
interface ctm_link_if;
	logic hostTxInput;
	logic hostRxOutput;
	logic cmdValid;
	logic cmdSetMode;
	logic [1:0] cmdCanMode;
	logic cmdSetSys;
	logic [2:0] cmdSysMode;
	logic cmdClearFlags;
	logic [2:0] sysMode;
	logic [1:0] canMode;
	logic busWakeFlag;
	logic [2:0] diagCode;
	logic alertN;

	modport device (
		input hostTxInput, cmdValid, cmdSetMode, cmdCanMode, cmdSetSys,
		input cmdSysMode, cmdClearFlags,
		output hostRxOutput, sysMode, canMode, busWakeFlag, diagCode, alertN
	);
	modport host (
		output hostTxInput, cmdValid, cmdSetMode, cmdCanMode, cmdSetSys,
		output cmdSysMode, cmdClearFlags,
		input hostRxOutput, sysMode, canMode, busWakeFlag, diagCode, alertN
	);
endinterface

// file: core/ctm_device.sv
// Purpose: transceiver mode, wake and fault supervision of the device end
// Assumes: bus and receive pin levels arrive asynchronously
// Notes: wake filter, transmit and bus timers count mclk cycles
module ctm_device
	import ctm_pkg::*;
#(
	parameter int WAKE_CYC = ctm_pkg::CTM_WAKE_FILTER_CYC,
	parameter int TXTO_CYC = ctm_pkg::CTM_TX_TIMEOUT_CYC,
	parameter int BUSTO_CYC = ctm_pkg::CTM_BUS_TIMEOUT_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// link to host
	ctm_link_if.device link,
	// bus side
	input wire logic busDominant,
	input wire logic rxPinSense,
	output logic busDrive,
	output logic driverEnable,
	// alert masks
	input wire logic alertMaskWake,
	input wire logic alertMaskFault
);
	import ctm_pkg::*;

	ctm_can_mode_t canMode;
	ctm_sys_mode_t sysMode;
	logic busS1, busS2, rxS1, rxS2;
	logic [CTM_CNT_W-1:0] wakeCnt, txCnt, busCnt;
	logic wakeEvent, txTimeout, busClamp, shortFault, rxFault;
	logic wakeArmed, wakeFlag, alertFromWake, txInhibit;
	logic [2:0] diag;
	logic rxLow;
	logic isSleepCmd;
	ctm_sys_mode_t next_sysMode;

	function automatic logic modeAllowed(input logic [2:0] s,
		input logic [1:0] m);
		unique case (s)
		CTM_SYS_INIT, CTM_SYS_FFLASH: modeAllowed = (m == CTM_CAN_OFF);
		CTM_SYS_NORMAL: modeAllowed = 1'b1;
		CTM_SYS_STOP, CTM_SYS_SLEEP, CTM_SYS_RESTART:
			modeAllowed = (m == CTM_CAN_OFF) || (m == CTM_CAN_WAKE);
		CTM_SYS_FAILSAFE: modeAllowed = (m == CTM_CAN_WAKE);
		CTM_SYS_SWFLASH: modeAllowed = (m == CTM_CAN_NORMAL);
		endcase
	endfunction

	// pin synchronisers
	always_ff @(posedge mclk) begin
		busS1 <= busDominant;
		busS2 <= busS1;
		rxS1 <= rxPinSense;
		rxS2 <= rxS1;
	end

	// wake filter, active only in wake-capable mode
	always_ff @(posedge mclk) begin
		if (!nrst || !busS2 || canMode != CTM_CAN_WAKE) begin
			wakeCnt <= '0;
		end else if (wakeCnt < CTM_CNT_W'(WAKE_CYC)) begin
			wakeCnt <= wakeCnt + 1'b1;
		end
	end
	assign wakeEvent = (wakeCnt == CTM_CNT_W'(WAKE_CYC - 1)) && busS2
		&& wakeArmed && canMode == CTM_CAN_WAKE;

	// transmit dominant timer
	always_ff @(posedge mclk) begin
		if (!nrst || link.hostTxInput) begin
			txCnt <= '0;
		end else if (txCnt < CTM_CNT_W'(TXTO_CYC)) begin
			txCnt <= txCnt + 1'b1;
		end
	end
	assign txTimeout = (txCnt == CTM_CNT_W'(TXTO_CYC));

	// bus dominant timer in active modes
	always_ff @(posedge mclk) begin
		if (!nrst || !busS2 || canMode == CTM_CAN_WAKE
			|| canMode == CTM_CAN_OFF) begin
			busCnt <= '0;
		end else if (busCnt < CTM_CNT_W'(BUSTO_CYC)) begin
			busCnt <= busCnt + 1'b1;
		end
	end
	assign busClamp = (busCnt == CTM_CNT_W'(BUSTO_CYC));

	// receive pin stuck recessive while bus dominant; short when
	// receive pin copies transmit while bus stays recessive
	assign rxFault = busS2 && rxS2 && canMode == CTM_CAN_NORMAL
		&& busCnt == CTM_CNT_W'(BUSTO_CYC / 2);
	assign shortFault = canMode == CTM_CAN_NORMAL && !busS2
		&& !link.hostTxInput && !rxS2 && !txInhibit;

	assign isSleepCmd = link.cmdValid && link.cmdSetSys
		&& link.cmdSysMode == CTM_SYS_SLEEP;

	// next system mode; a wake beats a sleep command in flight
	always_comb begin
		next_sysMode = sysMode;
		if (wakeEvent && (isSleepCmd || (sysMode != CTM_SYS_NORMAL
			&& sysMode != CTM_SYS_STOP))) begin
			next_sysMode = CTM_SYS_RESTART;
		end else if (link.cmdValid && link.cmdSetSys) begin
			next_sysMode = ctm_sys_mode_t'(link.cmdSysMode);
		end
	end

	// system mode
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			sysMode <= CTM_SYS_INIT;
		end else begin
			sysMode <= next_sysMode;
		end
	end

	// transceiver mode
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			canMode <= CTM_CAN_OFF;
		end else if (next_sysMode == CTM_SYS_FAILSAFE) begin
			canMode <= CTM_CAN_WAKE;
		end else if (next_sysMode == CTM_SYS_INIT
			|| next_sysMode == CTM_SYS_FFLASH) begin
			canMode <= CTM_CAN_OFF;
		end else if (next_sysMode == CTM_SYS_SWFLASH) begin
			canMode <= CTM_CAN_NORMAL;
		end else if ((busClamp || rxFault) && canMode == CTM_CAN_NORMAL
			&& next_sysMode == CTM_SYS_NORMAL) begin
			canMode <= CTM_CAN_RXONLY;
		end else if (link.cmdValid && link.cmdSetMode && !isSleepCmd
			&& modeAllowed(next_sysMode, link.cmdCanMode)) begin
			canMode <= ctm_can_mode_t'(link.cmdCanMode);
		end else if (!modeAllowed(next_sysMode, canMode)) begin
			canMode <= CTM_CAN_WAKE;
		end
	end

	// wake arming: spent by a wake, restored on leaving wake mode
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			wakeArmed <= 1'b1;
		end else if (wakeEvent) begin
			wakeArmed <= 1'b0;
		end else if (canMode != CTM_CAN_WAKE) begin
			wakeArmed <= 1'b1;
		end
	end

	// sticky wake flag, set wins over clear
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			wakeFlag <= 1'b0;
			alertFromWake <= 1'b0;
			rxLow <= 1'b0;
		end else if (wakeEvent) begin
			wakeFlag <= 1'b1;
			alertFromWake <= sysMode == CTM_SYS_STOP
				|| sysMode == CTM_SYS_NORMAL;
			rxLow <= 1'b1;
		end else begin
			if (link.cmdValid && link.cmdClearFlags) begin
				wakeFlag <= 1'b0;
				alertFromWake <= 1'b0;
			end
			if (canMode == CTM_CAN_NORMAL || canMode == CTM_CAN_RXONLY) begin
				rxLow <= 1'b0;
			end
		end
	end

	// diagnostic code and driver inhibit
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			diag <= CTM_DIAG_NONE;
		end else if (txTimeout && canMode == CTM_CAN_NORMAL) begin
			diag <= CTM_DIAG_TX_GND;
		end else if (busClamp) begin
			diag <= CTM_DIAG_BUS_DOM;
		end else if (shortFault) begin
			diag <= CTM_DIAG_TXRX_SHORT;
		end else if (rxFault) begin
			diag <= CTM_DIAG_RX_PIN;
		end else if (link.cmdValid && link.cmdClearFlags) begin
			diag <= CTM_DIAG_NONE;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			txInhibit <= 1'b0;
		end else if ((txTimeout && canMode == CTM_CAN_NORMAL)
			|| shortFault) begin
			txInhibit <= 1'b1;
		end else if (link.cmdValid && link.cmdSetMode
			&& link.cmdCanMode == CTM_CAN_NORMAL) begin
			txInhibit <= 1'b0;
		end
	end

	// bus driver outputs
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			busDrive <= 1'b1;
			driverEnable <= 1'b0;
		end else begin
			driverEnable <= canMode == CTM_CAN_NORMAL && !txInhibit;
			busDrive <= link.hostTxInput;
		end
	end

	// receive output: bus level in active modes, low after wake
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			link.hostRxOutput <= 1'b1;
		end else if (rxLow) begin
			link.hostRxOutput <= 1'b0;
		end else if (canMode == CTM_CAN_NORMAL
			|| canMode == CTM_CAN_RXONLY) begin
			link.hostRxOutput <= !busS2;
		end else begin
			link.hostRxOutput <= 1'b1;
		end
	end

	assign link.sysMode = sysMode;
	assign link.canMode = canMode;
	assign link.busWakeFlag = wakeFlag;
	assign link.diagCode = diag;
	assign link.alertN = !((alertFromWake && !alertMaskWake)
		|| (diag != CTM_DIAG_NONE && diag != CTM_DIAG_RX_PIN
		&& !alertMaskFault));
endmodule

// file: core/ctm_host.sv
// Purpose: host end, turns register writes into link commands
// Assumes: AXI4-Lite, one word per register
// Notes: read replies come one cycle after the request is taken, write replies two cycles after
module ctm_host
	import ctm_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// link to device
	ctm_link_if.host link,
	// user transmit and receive levels
	input wire logic userTx,
	output logic userRx,
	// axi4-lite slave
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	import ctm_pkg::*;
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;

	logic awHeld, wHeld;
	logic [3:0] awAddrHeld;
	logic [31:0] wDataHeld;
	logic doWrite;

	assign awready = !awHeld && !bvalid;
	assign wready = !wHeld && !bvalid;
	assign doWrite = awHeld && wHeld && !bvalid;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddrHeld <= 4'h0;
			wDataHeld <= 32'h0;
			bvalid <= 1'b0;
			bresp <= 2'h0;
		end else begin
			if (awvalid && awready) begin
				awHeld <= 1'b1;
				awAddrHeld <= awaddr;
			end
			if (wvalid && wready) begin
				wHeld <= 1'b1;
				wDataHeld <= wdata;
			end
			if (doWrite) begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				bvalid <= 1'b1;
				bresp <= (awAddrHeld == REG_CMD) ? 2'h0 : 2'h2;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// command word: bit0 set mode, [2:1] mode, bit3 set system,
	// [6:4] system, bit7 clear flags; mode with sleep is dropped
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			link.cmdValid <= 1'b0;
			link.cmdSetMode <= 1'b0;
			link.cmdCanMode <= 2'h0;
			link.cmdSetSys <= 1'b0;
			link.cmdSysMode <= 3'h0;
			link.cmdClearFlags <= 1'b0;
		end else begin
			link.cmdValid <= doWrite && awAddrHeld == REG_CMD && wstrb != 4'h0;
			link.cmdSetMode <= wDataHeld[0] && !(wDataHeld[3]
				&& wDataHeld[6:4] == CTM_SYS_SLEEP);
			link.cmdCanMode <= wDataHeld[2:1];
			link.cmdSetSys <= wDataHeld[3];
			link.cmdSysMode <= wDataHeld[6:4];
			link.cmdClearFlags <= wDataHeld[7];
		end
	end

	assign arready = !rvalid;
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= 2'h0;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp <= (araddr == REG_STAT) ? 2'h0 : 2'h2;
			rdata <= (araddr == REG_STAT) ? {22'h0, link.alertN,
				link.diagCode, link.busWakeFlag, link.canMode,
				link.sysMode} : 32'h0;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			link.hostTxInput <= 1'b1;
			userRx <= 1'b1;
		end else begin
			link.hostTxInput <= userTx;
			userRx <= link.hostRxOutput;
		end
	end
endmodule

// file: verif/ctm_link_assertions.sv
// Purpose: temporal checks on the host-device link
// Assumes: single mclk domain, nrst low resets
// Notes: sees only link signals, so alert masks are not observed
module ctm_link_assertions
	import ctm_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// commands
	input wire logic cmdValid,
	input wire logic cmdSetMode,
	input wire logic [1:0] cmdCanMode,
	input wire logic cmdSetSys,
	input wire logic cmdClearFlags,
	// device state
	input wire logic [2:0] sysMode,
	input wire logic [1:0] canMode,
	input wire logic busWakeFlag,
	input wire logic [2:0] diagCode,
	input wire logic alertN,
	input wire logic hostRxOutput
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	sequence s_wake(logic [2:0] m);
		$rose(busWakeFlag) && $past(sysMode) == m;
	endsequence
	sequence s_cmd(logic [1:0] m);
		cmdValid && cmdSetMode && !cmdSetSys && cmdCanMode == m;
	endsequence
	a_normal_gate: assert property (canMode == CTM_CAN_NORMAL |->
		sysMode inside {CTM_SYS_NORMAL, CTM_SYS_SWFLASH})
		else $error("normal mode in wrong system mode");
	a_stop_column: assert property (sysMode == CTM_SYS_STOP |->
		canMode inside {CTM_CAN_OFF, CTM_CAN_WAKE})
		else $error("illegal mode in stop");
	a_failsafe_wake: assert property (sysMode == CTM_SYS_FAILSAFE ##1
		sysMode == CTM_SYS_FAILSAFE |-> canMode == CTM_CAN_WAKE)
		else $error("fail-safe without wake mode");
	a_init_off: assert property ($past(sysMode) == CTM_SYS_INIT &&
		sysMode == CTM_SYS_INIT |-> canMode == CTM_CAN_OFF)
		else $error("init without off mode");
	a_off_cmd: assert property (s_cmd(CTM_CAN_OFF) ##0 sysMode inside
		{CTM_SYS_NORMAL, CTM_SYS_STOP, CTM_SYS_SLEEP, CTM_SYS_RESTART}
		|=> canMode == CTM_CAN_OFF)
		else $error("off command not taken");
	a_rxonly_cmd: assert property (s_cmd(CTM_CAN_RXONLY) ##0
		sysMode == CTM_SYS_NORMAL |=> canMode == CTM_CAN_RXONLY)
		else $error("receive only command not taken");
	a_off_deaf: assert property ($past(canMode) == CTM_CAN_OFF &&
		canMode == CTM_CAN_OFF |-> !$rose(busWakeFlag))
		else $error("wake seen in off mode");
	a_stop_wake: assert property (s_wake(CTM_SYS_STOP) |->
		##[0:2] (!hostRxOutput && sysMode == CTM_SYS_STOP))
		else $error("stop wake handling wrong");
	a_sleep_wake: assert property (s_wake(CTM_SYS_SLEEP) |->
		##[0:2] sysMode == CTM_SYS_RESTART)
		else $error("sleep wake did not restart");
	a_sleep_quiet: assert property (s_wake(CTM_SYS_SLEEP) |->
		$stable(alertN))
		else $error("alert raised on sleep wake");
	a_flag_sticky: assert property (busWakeFlag &&
		!(cmdValid && cmdClearFlags) |=> busWakeFlag)
		else $error("wake flag lost without clear");
	a_clamp_rxonly: assert property ($changed(diagCode) &&
		diagCode == CTM_DIAG_BUS_DOM && sysMode == CTM_SYS_NORMAL
		|-> ##[0:1] canMode == CTM_CAN_RXONLY)
		else $error("bus clamp kept driver mode");
endmodule

// file: verif/tb_can_transceiver_mode_ctrl.sv
// Purpose: host and device ends joined, driven over AXI4-Lite
// Assumes: short counts 4/20/40, bus modelled from driver outputs
// Notes: alert masks mostly open so flags reach the alert line, except the receive pin code and wakes outside stop and normal
module tb_can_transceiver_mode_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	import ctm_pkg::*;
	logic mclk = 1'h0;
	logic nrst, userTx, userRx, busForce, busBlock, maskWake, maskFault;
	logic [1:0] rxOvr, bresp, rresp, r;
	logic [3:0] awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic busDrive, driverEnable, busDominant, rxPinSense;
	logic [31:0] wdata, rdata, d;
	int bad_count, tests_run;
	ctm_link_if lnk();
	// bus wire: driver, or a forced clamp; receive pin may be overridden
	assign busDominant = (driverEnable && !busDrive && !busBlock) || busForce;
	assign rxPinSense = (rxOvr == 2'h0) ? !busDominant : rxOvr[0];
	always #50 mclk = ~mclk;
	ctm_host u_ctm_host (.mclk, .nrst, .link(lnk), .userTx, .userRx,
		.awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready);
	ctm_device #(.WAKE_CYC(4), .TXTO_CYC(20), .BUSTO_CYC(40)) u_ctm_device (
		.mclk, .nrst, .link(lnk), .busDominant, .rxPinSense, .busDrive,
		.driverEnable, .alertMaskWake(maskWake), .alertMaskFault(maskFault));
	ctm_link_assertions u_ctm_link_assertions (.mclk, .nrst,
		.cmdValid(lnk.cmdValid), .cmdSetMode(lnk.cmdSetMode),
		.cmdCanMode(lnk.cmdCanMode), .cmdSetSys(lnk.cmdSetSys),
		.cmdClearFlags(lnk.cmdClearFlags), .sysMode(lnk.sysMode),
		.canMode(lnk.canMode), .busWakeFlag(lnk.busWakeFlag),
		.diagCode(lnk.diagCode), .alertN(lnk.alertN),
		.hostRxOutput(lnk.hostRxOutput));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task cyc(input int k);
		repeat (k) @(posedge mclk);
	endtask
	task wr(input logic [3:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge mclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge mclk);
			n++;
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!bvalid && n < 200);
		bready <= 1'h0;
		r = bresp;
	endtask
	task rd(input logic [3:0] a);
		int n;
		n = 0;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge mclk);
			n++;
			if (arready) arvalid <= 1'h0;
		end while (!rvalid && n < 200);
		rready <= 1'h0;
		d = rdata;
		r = rresp;
	endtask
	task cmd(input logic [7:0] c);
		wr(4'h0, {24'h0, c});
		chk({30'h0, r}, 32'h0);
	endtask
	task md(input ctm_can_mode_t m);
		cmd({5'h0, m, 1'h1});
	endtask
	task sy(input ctm_sys_mode_t s);
		cmd({1'h0, s, 4'h8});
	endtask
	task st(input ctm_sys_mode_t s, input ctm_can_mode_t m, input logic f,
		input logic [2:0] g, input logic a);
		rd(4'h4);
		chk(d, {22'h0, a, g, f, m, s});
	endtask
	task dg(input logic [2:0] g);
		rd(4'h4);
		chk({29'h0, d[8:6]}, {29'h0, g});
	endtask
	task bump(input int k);
		busForce <= 1'h1;
		cyc(k);
		busForce <= 1'h0;
		cyc(4);
	endtask
	initial begin
		repeat (5000) @(posedge mclk);
		bad_count++;
		report_and_stop;
	end
	initial begin
		{nrst, busForce, busBlock, awvalid, wvalid, bready} = 6'h0;
		{maskWake, maskFault} = 2'h0;
		{arvalid, rready, rxOvr, awaddr, araddr, wdata} = 44'h0;
		{userTx, bad_count, tests_run} = 65'h1_0000_0000_0000_0000;
		repeat (6) @(posedge mclk);
		nrst <= 1'h1;
		st(CTM_SYS_INIT, CTM_CAN_OFF, 1'h0, CTM_DIAG_NONE, 1'h1);
		md(CTM_CAN_NORMAL);
		st(CTM_SYS_INIT, CTM_CAN_OFF, 1'h0, CTM_DIAG_NONE, 1'h1);
		sy(CTM_SYS_NORMAL);
		md(CTM_CAN_NORMAL);
		st(CTM_SYS_NORMAL, CTM_CAN_NORMAL, 1'h0, 3'h0, 1'h1);
		userTx <= 1'h0;
		cyc(4);
		chk({31'h0, busDominant}, 32'h1);
		userTx <= 1'h1;
		cyc(4);
		chk({31'h0, busDominant}, 32'h0);
		md(CTM_CAN_RXONLY);
		st(CTM_SYS_NORMAL, CTM_CAN_RXONLY, 1'h0, 3'h0, 1'h1);
		chk({31'h0, driverEnable}, 32'h0);
		md(CTM_CAN_NORMAL);
		userTx <= 1'h0;
		cyc(30);
		chk({31'h0, busDominant}, 32'h0);
		userTx <= 1'h1;
		dg(CTM_DIAG_TX_GND);
		cmd(8'h80);
		md(CTM_CAN_NORMAL);
		userTx <= 1'h0;
		cyc(3);
		chk({31'h0, busDominant}, 32'h1);
		userTx <= 1'h1;
		bump(50);
		st(CTM_SYS_NORMAL, CTM_CAN_RXONLY, 1'h0, CTM_DIAG_BUS_DOM, 1'h0);
		cmd(8'h80);
		md(CTM_CAN_NORMAL);
		st(CTM_SYS_NORMAL, CTM_CAN_NORMAL, 1'h0, 3'h0, 1'h1);
		rxOvr <= 2'h1;
		bump(26);
		rxOvr <= 2'h0;
		dg(CTM_DIAG_RX_PIN);
		cmd(8'h80);
		md(CTM_CAN_NORMAL);
		{userTx, busBlock, rxOvr} <= 4'h6;
		cyc(6);
		{userTx, busBlock, rxOvr} <= 4'h8;
		dg(CTM_DIAG_TXRX_SHORT);
		chk({31'h0, lnk.alertN}, 32'h0);
		maskFault <= 1'h1;
		cyc(1);
		chk({31'h0, lnk.alertN}, 32'h1);
		maskFault <= 1'h0;
		cmd(8'h80);
		md(CTM_CAN_NORMAL);
		md(CTM_CAN_WAKE);
		sy(CTM_SYS_STOP);
		bump(8);
		st(CTM_SYS_STOP, CTM_CAN_WAKE, 1'h1, 3'h0, 1'h0);
		chk({31'h0, userRx}, 32'h0);
		maskWake <= 1'h1;
		cyc(1);
		chk({31'h0, lnk.alertN}, 32'h1);
		maskWake <= 1'h0;
		sy(CTM_SYS_NORMAL);
		cmd(8'h80);
		md(CTM_CAN_NORMAL);
		md(CTM_CAN_WAKE);
		sy(CTM_SYS_SLEEP);
		bump(8);
		st(CTM_SYS_RESTART, CTM_CAN_WAKE, 1'h1, 3'h0, 1'h1);
		cmd(8'h80);
		sy(CTM_SYS_NORMAL);
		md(CTM_CAN_OFF);
		sy(CTM_SYS_SLEEP);
		bump(8);
		st(CTM_SYS_SLEEP, CTM_CAN_OFF, 1'h0, 3'h0, 1'h1);
		sy(CTM_SYS_FAILSAFE);
		st(CTM_SYS_FAILSAFE, CTM_CAN_WAKE, 1'h0, 3'h0, 1'h1);
		bump(8);
		st(CTM_SYS_RESTART, CTM_CAN_WAKE, 1'h1, 3'h0, 1'h1);
		cmd(8'h80);
		sy(CTM_SYS_SWFLASH);
		st(CTM_SYS_SWFLASH, CTM_CAN_NORMAL, 1'h0, 3'h0, 1'h1);
		sy(CTM_SYS_FFLASH);
		st(CTM_SYS_FFLASH, CTM_CAN_OFF, 1'h0, 3'h0, 1'h1);
		wr(4'h8, 32'h0);
		chk({30'h0, r}, 32'h2);
		rd(4'h8);
		chk({30'h0, r}, 32'h2);
		report_and_stop;
	end
endmodule
